// File: rtl/vcm_pkg.sv
// Shared constants, decode helpers and state type for the chained readout and multicast slave.
package vcm_pkg;

    // Address modifiers of the VME standard that this block answers.
    localparam logic [5:0] AM_BLT32_USER  = 6'h0b;
    localparam logic [5:0] AM_BLT32_SUPV  = 6'h0f;
    localparam logic [5:0] AM_MBLT64_USER = 6'h08;
    localparam logic [5:0] AM_MBLT64_SUPV = 6'h0c;
    localparam logic [5:0] AM_A32_USER    = 6'h09;
    localparam logic [5:0] AM_A32_SUPV    = 6'h0d;

    // Field positions inside the 32-bit address.
    localparam int         BASE_MSB       = 31;
    localparam int         BASE_LSB       = 24;
    localparam int         OFFS_MSB       = 23;
    localparam logic [23:0] OFFS_ZERO     = 24'h000000;

    // Multi-event store window: offsets below this limit select the store.
    localparam logic [23:0] STORE_LIMIT   = 24'h001000;

    // Event buffer geometry, pin synchroniser width and reset values.
    localparam int         WORD_W         = 32;
    localparam int         FIFO_DEPTH     = 8;
    localparam int         SYNC_W         = 75;
    localparam logic [31:0] DATA_RST      = 32'h00000000;
    localparam logic [15:0] OFFS_RST      = 16'h0000;

    // One-hot states of the bus cycle engine.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BEAT = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_SKIP = 4'b1000
    } vcm_state_e;

    // True for the four block transfer modifiers a chained read may use.
    function automatic logic vcmIsChainAm(input logic [5:0] am);
        vcmIsChainAm = (am == AM_BLT32_USER) || (am == AM_BLT32_SUPV) ||
                       (am == AM_MBLT64_USER) || (am == AM_MBLT64_SUPV);
    endfunction : vcmIsChainAm

    // True for the 64-bit multiplexed block transfer modifiers.
    function automatic logic vcmIs64Am(input logic [5:0] am);
        vcmIs64Am = (am == AM_MBLT64_USER) || (am == AM_MBLT64_SUPV);
    endfunction : vcmIs64Am

    // True for single A32 data accesses, the carrier of multicast writes.
    function automatic logic vcmIsCastAm(input logic [5:0] am);
        vcmIsCastAm = (am == AM_A32_USER) || (am == AM_A32_SUPV);
    endfunction : vcmIsCastAm

endpackage : vcm_pkg

// File: rtl/vcm_event_fifo.sv
// Synchronous FIFO holding event words between acquisition and bus readout.
`timescale 1ns/10ps
module vcm_event_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,   // System clock.
    input  wire logic             reset,     // Asynchronous reset, active high.
    input  wire logic [WIDTH-1:0] inData,    // Word offered by the filling side.
    input  wire logic             inValid,   // Filling side has a word.
    output logic                  inReady,   // FIFO can take a word.
    output logic      [WIDTH-1:0] outData,   // Oldest word.
    output logic                  outValid,  // A word is waiting.
    input  wire logic             outReady   // Draining side takes the word.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count, so both are exact.
    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign outData  = store[rdPtr_r];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Storage array is written only, never reset, to keep it as plain memory.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wrPtr_r] <= inData;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end

    // Occupancy tracks simultaneous push and pop as no change.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

endmodule : vcm_event_fifo

// File: rtl/vcm_chain_slave.sv
// Chained block readout and multicast write slave for one board in a VME crate.
//
// What this block does
// - Chained accesses are read cycles only; multicast accesses are write cycles only.
// - Common base is the programmed upper byte with all lower 24 bits zero.
// - Chained reads answer only to 32-bit block or 64-bit multiplexed modifiers.
// - Chained reads serve the multi-event store only, at base plus store offsets.
// - Head board sends its data, then marks itself done after the trailer word.
// - A done board stays out and passes the token to the next board.
// - Last board holding the token and already done raises BERR.
// - In 64-bit chained mode the address beat is acknowledged with DTACK.
// - With auto advance on, every word read advances the event pointer.
// - With auto advance off, the pointer stays and the header repeats.
// - An interrupted readout resumes at the board holding the token.
// - Multicast write updates this board's register at base plus its offset.
`timescale 1ns/10ps
module vcm_chain_slave
    import vcm_pkg::*;
(
    input  wire logic        clk_sys,            // System clock, 40 MHz.
    input  wire logic        reset,              // Asynchronous reset, active high.
    input  wire logic [31:0] vmeAddr,            // Address lines.
    input  wire logic [5:0]  vmeAm,              // Address modifier lines.
    input  wire logic        vmeAsN,             // Address strobe, active low.
    input  wire logic        vmeDsN,             // Data strobe, active low.
    input  wire logic        vmeWriteN,          // Write line, low for write.
    input  wire logic        vmeIackinN,         // Incoming token, active low.
    input  wire logic        vmeBerrInN,         // Bus error as seen on the bus.
    input  wire logic [31:0] vmeDataIn,          // Data lines as seen on the bus.
    output logic      [31:0] vmeDataOut,         // Data driven onto the bus.
    output logic             vmeDataOeN,         // Data output enable, low drives.
    output logic             vmeDtackOut,        // Acknowledge level, always low.
    output logic             vmeDtackOeN,        // Acknowledge enable, low drives.
    output logic             vmeBerrOut,         // Bus error level, always low.
    output logic             vmeBerrOeN,         // Bus error enable, low drives.
    output logic             vmeIackoutN,        // Outgoing token, active low.
    input  wire logic [7:0]  chainBaseHigh,      // Shared upper address byte.
    input  wire logic        chainHead,          // This board heads the chain.
    input  wire logic        chainTail,          // This board ends the chain.
    input  wire logic        pointer_auto_advance, // Advance pointer on every word read.
    output logic             readoutDone,        // Board has sent its event.
    input  wire logic [31:0] evWord,             // Event word from acquisition.
    input  wire logic        evTrailer,          // Word is the block trailer word.
    input  wire logic        evValid,            // Acquisition offers a word.
    output logic             evReady,            // Event buffer can take it.
    output logic             castWrStb,          // Multicast register write pulse.
    output logic      [15:0] castOffset,         // Register offset of that write.
    output logic      [31:0] castData            // Data of that write.
);

    vcm_state_e       state_r;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync3_r;
    logic [SYNC_W-1:0] pinF_r;
    logic [31:0]      addrF;
    logic [31:0]      dataF;
    logic [5:0]       amF;
    logic             asF;
    logic             dsF;
    logic             writeF;
    logic             tokenF;
    logic             berrF;
    logic             baseHit;
    logic             storeHit;
    logic             inChain;
    logic             addrAcked_r;
    logic             beat64_r;
    logic             purged_r;
    logic             berrSeen_r;
    logic             dtackDrv_r;
    logic             berrDrv_r;
    logic             dataDrv_r;
    logic [31:0]      dataOut_r;
    logic             castStb_r;
    logic [15:0]      castOffs_r;
    logic [31:0]      castData_r;
    logic             tokenOut_r;
    logic [32:0]      fifoWord;
    logic             fifoValid;
    logic             fifoPop;
    logic             sendWord;

    // Event words queue here; a slow reader stalls acquisition through evReady.
    vcm_event_fifo #(
        .WIDTH (WORD_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_event_fifo (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .inData   ({evTrailer, evWord}),
        .inValid  (evValid),
        .inReady  (evReady),
        .outData  (fifoWord),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // Three-stage pin synchroniser; a bit changes once stages two and three agree.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
        end else begin
            sync1_r <= {vmeAsN, vmeDsN, vmeWriteN, vmeIackinN, vmeBerrInN, vmeAm, vmeAddr, vmeDataIn};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Filtered pin image, updated per bit only where the late stages agree.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pinF_r <= '1;
        end else begin
            pinF_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (pinF_r & (sync2_r ^ sync3_r));
        end
    end

    // Unpack the filtered image; strobes turned to active high.
    assign asF     = ~pinF_r[74];
    assign dsF     = ~pinF_r[73];
    assign writeF  = ~pinF_r[72];
    assign tokenF  = ~pinF_r[71];
    assign berrF   = ~pinF_r[70];
    assign amF     = pinF_r[69:64];
    assign addrF   = pinF_r[63:32];
    assign dataF   = pinF_r[31:0];

    // Common base is the shared byte over a zero lower field.
    assign baseHit  = (addrF[BASE_MSB:BASE_LSB] == chainBaseHigh);
    assign storeHit = (addrF[OFFS_MSB:0] - OFFS_ZERO) < STORE_LIMIT;
    // The head always takes part; others wait for the token from upstream.
    assign inChain  = chainHead || tokenF;
    // A word goes out only while the board still owes data.
    assign sendWord = (state_r == ST_BEAT) && !(beat64_r && !addrAcked_r) && !purged_r && fifoValid;
    // Without auto advance the pointer never moves and the header repeats.
    assign fifoPop  = sendWord && pointer_auto_advance;

    // Bus cycle engine; one decision per data strobe.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (asF && dsF) begin
                        if (!baseHit) begin
                            state_r <= ST_SKIP;
                        end else if (vcmIsChainAm(amF) && !writeF && storeHit && inChain) begin
                            state_r <= ST_BEAT;
                        end else if (vcmIsCastAm(amF) && writeF) begin
                            state_r <= ST_HOLD;
                        end else begin
                            state_r <= ST_SKIP;
                        end
                    end
                end
                ST_BEAT: begin
                    if (sendWord || (beat64_r && !addrAcked_r) || chainTail) begin
                        state_r <= ST_HOLD;
                    end else begin
                        state_r <= ST_SKIP;
                    end
                end
                ST_HOLD: begin
                    if (!dsF) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SKIP: begin
                    if (!asF) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Width of the block transfer is latched at the cycle start for the beat decision.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            beat64_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            beat64_r <= vcmIs64Am(amF);
        end
    end

    // The 64-bit address beat is acknowledged once per address strobe.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addrAcked_r <= 1'b0;
        end else if (!asF) begin
            addrAcked_r <= 1'b0;
        end else if (state_r == ST_BEAT && beat64_r) begin
            addrAcked_r <= 1'b1;
        end
    end

    // Done flag; it survives an interrupted readout so the token stays put.
    // Cleared once the crate has seen BERR and the strobe is gone; a set wins.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            purged_r <= 1'b0;
        end else if (sendWord && fifoWord[WORD_W]) begin
            purged_r <= 1'b1;
        end else if (state_r == ST_BEAT && !(beat64_r && !addrAcked_r) && !fifoValid) begin
            purged_r <= 1'b1;
        end else if (berrSeen_r && !asF) begin
            purged_r <= 1'b0;
        end
    end

    // Remembers that a chained readout ended with BERR on the bus.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            berrSeen_r <= 1'b0;
        end else if (asF && berrF && vcmIsChainAm(amF)) begin
            berrSeen_r <= 1'b1;
        end else if (!asF) begin
            berrSeen_r <= 1'b0;
        end
    end

    // Acknowledge, error and data drivers, released when the data strobe goes.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dtackDrv_r <= 1'b0;
            berrDrv_r  <= 1'b0;
            dataDrv_r  <= 1'b0;
        end else if (state_r == ST_IDLE && asF && dsF && baseHit && vcmIsCastAm(amF) && writeF) begin
            dtackDrv_r <= chainTail;
        end else if (state_r == ST_BEAT) begin
            dtackDrv_r <= sendWord || (beat64_r && !addrAcked_r);
            dataDrv_r  <= sendWord;
            berrDrv_r  <= !sendWord && !(beat64_r && !addrAcked_r) && chainTail;
        end else if (!dsF) begin
            dtackDrv_r <= 1'b0;
            berrDrv_r  <= 1'b0;
            dataDrv_r  <= 1'b0;
        end
    end

    // Read data register; holds the word for the whole beat.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dataOut_r <= DATA_RST;
        end else if (sendWord) begin
            dataOut_r <= fifoWord[WORD_W-1:0];
        end
    end

    // Multicast write capture; every matching board updates, only the tail acknowledges.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            castStb_r  <= 1'b0;
            castOffs_r <= OFFS_RST;
            castData_r <= DATA_RST;
        end else begin
            castStb_r <= (state_r == ST_IDLE) && asF && dsF && baseHit && vcmIsCastAm(amF) && writeF;
            if ((state_r == ST_IDLE) && asF && dsF && baseHit && vcmIsCastAm(amF) && writeF) begin
                castOffs_r <= addrF[15:0];
                castData_r <= dataF;
            end
        end
    end

    // Token goes downstream once this board is done and holds the token itself.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tokenOut_r <= 1'b0;
        end else begin
            tokenOut_r <= purged_r && inChain && !chainTail;
        end
    end

    assign vmeDataOut  = dataOut_r;
    assign vmeDataOeN  = !dataDrv_r;
    assign vmeDtackOut = 1'b0;
    assign vmeDtackOeN = !dtackDrv_r;
    assign vmeBerrOut  = 1'b0;
    assign vmeBerrOeN  = !berrDrv_r;
    assign vmeIackoutN = !tokenOut_r;
    assign readoutDone = purged_r;
    assign castWrStb   = castStb_r;
    assign castOffset  = castOffs_r;
    assign castData    = castData_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Checks that guard the chaining and multicast behaviour.
    write_no_data_a: assert property (writeF |=> !dataDrv_r) else $error("Data driven in a write cycle.");
    foreign_base_a: assert property ((state_r == ST_IDLE) && asF && dsF && !baseHit |=> state_r == ST_SKIP)
        else $error("Foreign base address was answered.");
    chain_am_a: assert property ((state_r == ST_BEAT) |-> $past(vcmIsChainAm(amF)) && $past(!writeF))
        else $error("Chained beat without block read modifier.");
    trailer_done_a: assert property (sendWord && fifoWord[WORD_W] |=> readoutDone)
        else $error("Trailer sent but board not done.");
    done_silent_a: assert property (purged_r && (state_r == ST_BEAT)
        && !(beat64_r && !addrAcked_r) |=> !dataDrv_r) else $error("Done board still sends data.");
    tail_berr_a: assert property ((state_r == ST_BEAT) && purged_r && chainTail
        && !(beat64_r && !addrAcked_r) |=> berrDrv_r ##1 (berrDrv_r || !dsF))
        else $error("Done tail did not raise bus error.");
    addr_beat_a: assert property ((state_r == ST_BEAT) && beat64_r && !addrAcked_r
        |=> dtackDrv_r && !dataDrv_r) else $error("64-bit address beat not acknowledged.");
    // A frozen pointer must keep a waiting word waiting, whatever the engine decides.
    hold_pointer_a: assert property (!pointer_auto_advance && fifoValid |=> fifoValid)
        else $error("Pointer moved while frozen.");
    no_token_a: assert property (!chainHead && !tokenF && (state_r == ST_IDLE) |=> state_r != ST_BEAT)
        else $error("Chained read served without token.");
    cast_pulse_a: assert property (castWrStb |=> !castWrStb) else $error("Multicast strobe longer than one cycle.");

endmodule : vcm_chain_slave

// File: verif/vcm_host.sv
// Behavioural VME master model for one board.
`timescale 1ns/10ps
module vcm_host (
    input  wire logic        clk_sys,     // Clock.
    output logic      [31:0] vmeAddr,     // Address.
    output logic      [5:0]  vmeAm,       // Modifier.
    output logic             vmeAsN,      // Address strobe.
    output logic             vmeDsN,      // Data strobe.
    output logic             vmeWriteN,   // Low writes.
    output logic             vmeBerrInN,  // Resolved BERR.
    output logic      [31:0] vmeDataIn,   // Resolved data.
    input  wire logic [31:0] vmeDataOut,  // Board data.
    input  wire logic        vmeDataOeN,  // Board drives data.
    input  wire logic        vmeDtackOeN, // Board pulls DTACK.
    input  wire logic        vmeBerrOeN   // Board pulls BERR.
);
    logic [31:0] wData;
    logic [31:0] lastBus;
    // Released lines show the inverse of their last level, so stale data never matches.
    always @(posedge clk_sys) lastBus <= vmeDataIn;
    assign vmeDataIn  = !vmeWriteN ? wData : (!vmeDataOeN ? vmeDataOut : ~lastBus);
    assign vmeBerrInN = vmeBerrOeN; // Pulled-up line.
    initial begin
        {vmeAddr, vmeAm, wData} = '0;
        {vmeAsN, vmeDsN, vmeWriteN} = 3'h7;
    end
    // Address phase; the strobe stays low over all beats.
    task go(input logic [31:0] a, input logic [5:0] m, input logic wr, input logic [31:0] wd);
        @(posedge clk_sys) #2;
        vmeAddr = a;
        vmeAm = m;
        vmeWriteN = !wr;
        wData = wd;
        vmeAsN = 1'b0;
    endtask : go
    // One beat; code 1 is DTACK, 2 is BERR, 0 is silence for 16 cycles.
    task beat(output logic [31:0] d, output logic [1:0] c);
        int n;
        @(posedge clk_sys) #2;
        vmeDsN = 1'b0;
        c = 2'd0;
        for (n = 0; n < 16 && c == 2'd0; n++) begin
            @(posedge clk_sys);
            d = vmeDataIn;
            c = !vmeDtackOeN ? 2'd1 : (!vmeBerrOeN ? 2'd2 : 2'd0);
        end
        #2;
        vmeDsN = 1'b1;
        for (n = 0; n < 16 && !(vmeDtackOeN && vmeBerrOeN); n++) @(posedge clk_sys);
    endtask : beat
    // End of cycle; address strobe high between chained cycles.
    task stop;
        @(posedge clk_sys) #2;
        vmeAsN = 1'b1;
        vmeWriteN = 1'b1;
        repeat (6) @(posedge clk_sys);
        #2; // Callers change inputs next, so leave the sampling edge first.
    endtask : stop
endmodule : vcm_host

// File: verif/vcm_chain_slave_bench.sv
// Self-checking bench for the chained readout and multicast slave.
`timescale 1ns/10ps
module vcm_chain_slave_bench;
    import vcm_pkg::*;
    localparam logic [31:0] BASE = 32'h5a000000;
    logic        clk_sys, reset, vmeAsN, vmeDsN, vmeWriteN, vmeIackinN, vmeBerrInN, vmeDataOeN;
    logic        vmeDtackOeN, vmeBerrOeN, vmeIackoutN, chainHead, chainTail, pointer_auto_advance;
    logic        readoutDone, evTrailer, evValid, evReady, castWrStb, vmeDtackOut, vmeBerrOut;
    logic [31:0] vmeAddr, vmeDataIn, vmeDataOut, evWord, castData, d;
    logic [15:0] castOffset;
    logic [7:0]  chainBaseHigh;
    logic [5:0]  vmeAm;
    logic [1:0]  c;
    int          err_count, n_checks, nStb, cyc;
    vcm_chain_slave i_vcm_chain_slave (.clk_sys, .reset, .vmeAddr, .vmeAm, .vmeAsN, .vmeDsN, .vmeWriteN,
        .vmeIackinN, .vmeBerrInN, .vmeDataIn, .vmeDataOut, .vmeDataOeN, .vmeDtackOut, .vmeDtackOeN,
        .vmeBerrOut, .vmeBerrOeN, .vmeIackoutN, .chainBaseHigh, .chainHead, .chainTail,
        .pointer_auto_advance, .readoutDone, .evWord, .evTrailer, .evValid, .evReady, .castWrStb,
        .castOffset, .castData);
    vcm_host i_vcm_host (.clk_sys, .vmeAddr, .vmeAm, .vmeAsN, .vmeDsN, .vmeWriteN, .vmeBerrInN,
        .vmeDataIn, .vmeDataOut, .vmeDataOeN, .vmeDtackOeN, .vmeBerrOeN);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Strobe counter and hang guard; a held strobe counts once per cycle.
    always @(posedge clk_sys) begin
        nStb += (castWrStb === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task rd(input logic [31:0] ed, input logic [1:0] ec);
        i_vcm_host.beat(d, c);
        chk(c, ec);
        if (ec == 2'd1) chk(d, ed);
    endtask : rd
    task push(input logic [31:0] w, input logic t);
        @(posedge clk_sys) #2;
        {evWord, evTrailer, evValid} = {w, t, 1'b1};
        @(posedge clk_sys) #2;
        evValid = 1'b0;
    endtask : push
    // A done board in tail position ends the chain with BERR; that clears done.
    task clear_done;
        chainTail = 1'b1;
        i_vcm_host.go(BASE, AM_BLT32_USER, 1'b0, 0);
        rd(0, 2'd2);
        i_vcm_host.stop();
        chk(readoutDone, 0);
        chk(vmeIackoutN, 1);
        chainTail = 1'b0;
    endtask : clear_done
    task s_chain;
        int i;
        for (i = 0; i < 8; i++) push(32'h0a000000 + i, i == 7);
        chk(evReady, 0);
        i_vcm_host.go(BASE, AM_BLT32_USER, 1'b0, 0); // Few beats, well under 256
        for (i = 0; i < 8; i++) rd(32'h0a000000 + i, 2'd1);
        rd(0, 2'd0);
        chk(readoutDone, 1);
        chk(vmeIackoutN, 0);
        i_vcm_host.stop();
        chk(evReady, 1);
        clear_done();
    endtask : s_chain
    // Refused accesses, then a non-head board waiting for the token.
    task s_refuse;
        logic [31:0] ad [4] = '{BASE, BASE, 32'h5b000000, BASE + 32'h1000};
        logic [5:0]  am [4] = '{AM_A32_USER, AM_BLT32_USER, AM_BLT32_SUPV, AM_MBLT64_SUPV};
        int i;
        push(32'h11, 1'b1);
        for (i = 0; i < 4; i++) begin
            i_vcm_host.go(ad[i], am[i], i == 1, 0);
            rd(0, 2'd0);
            i_vcm_host.stop();
        end
        chk(nStb, 0);
        chainHead = 1'b0;
        i_vcm_host.go(BASE, AM_BLT32_USER, 1'b0, 0);
        rd(0, 2'd0);
        i_vcm_host.stop();
        vmeIackinN = 1'b0;
        i_vcm_host.go(BASE, AM_BLT32_USER, 1'b0, 0);
        rd(32'h11, 2'd1);
        i_vcm_host.stop();
        chk(vmeIackoutN, 0);
        clear_done();
        {vmeIackinN, chainHead} = 2'b11;
    endtask : s_refuse
    task s_modes;
        push(32'h22, 1'b0);
        push(32'h33, 1'b1);
        i_vcm_host.go(BASE, AM_MBLT64_USER, 1'b0, 0);
        i_vcm_host.beat(d, c);
        chk(c, 1);
        rd(32'h22, 2'd1);
        rd(32'h33, 2'd1);
        i_vcm_host.stop();
        clear_done();
        pointer_auto_advance = 1'b0;
        push(32'h44, 1'b0);
        push(32'h55, 1'b1);
        i_vcm_host.go(BASE, AM_BLT32_SUPV, 1'b0, 0);
        rd(32'h44, 2'd1);
        rd(32'h44, 2'd1);
        i_vcm_host.stop();
        chk(readoutDone, 0);
        pointer_auto_advance = 1'b1;
        i_vcm_host.go(BASE, AM_BLT32_USER, 1'b0, 0);
        rd(32'h44, 2'd1);
        rd(32'h55, 2'd1);
        i_vcm_host.stop();
        clear_done();
    endtask : s_modes
    // Multicast write at base plus 0x1010 acknowledged by the tail, then a single A32 read that is refused
    task s_cast;
        chainTail = 1'b1;
        i_vcm_host.go(BASE + 32'h1010, AM_A32_SUPV, 1'b1, 32'hcafe0001);
        rd(32'hcafe0001, 2'd1);
        i_vcm_host.stop();
        chk(nStb, 1);
        chk(castOffset, 16'h1010);
        chk(castData, 32'hcafe0001);
        i_vcm_host.go(BASE + 32'h1010, AM_A32_USER, 1'b0, 0);
        rd(0, 2'd0);
        i_vcm_host.stop();
        chk(nStb, 1);
    endtask : s_cast
    task wrap_up;
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        {err_count, n_checks, nStb, cyc} = '0;
        {reset, vmeIackinN, chainHead, pointer_auto_advance} = 4'hf;
        {chainTail, evValid, evTrailer, evWord} = '0;
        chainBaseHigh = 8'h5a; // Same byte on every board
        repeat (12) @(posedge clk_sys);
        #2 reset = 1'b0;
        chk({vmeDataOeN, vmeDtackOeN, vmeBerrOeN, vmeIackoutN, readoutDone}, 5'h1e);
        chk({vmeDtackOut, vmeBerrOut}, 2'h0);
        s_chain();
        s_refuse();
        s_modes();
        s_cast();
        wrap_up();
    end
endmodule : vcm_chain_slave_bench
